// >>> hbwu_top.sv
// Functional notes
// - each control register keeps an 8-bit thread mask in bits 23:16, reset zero, gating its point.
// - control bit 0 enables its point, resets to zero, and a disabled point never interrupts.
// - instruction control bit 1 clear breaks on pc equal to the address, set on pc different.
// - each data watchpoint has a first and a second 32-bit address register in two banks.
// - four data watchpoint control registers govern each watchpoint independently.
// - data control bit 2 lets the watchpoint trigger on loads and resets to zero.
// - data control bit 1 clear needs both conditions, set needs either one.
// - each resource watchpoint has a 32-bit mask register.
// - each resource watchpoint has a 32-bit comparison value register.
// - four resource control registers each hold enable, thread mask and condition select.
// - resource control bit 1 clear fires when the masked value equals the comparison value, set when it differs.
// - a trigger raises the debug interrupt and records cause code 3, 4 or 5 and the thread.
// - a data trigger captures the access address, a resource trigger the resource identifier.
// - four instruction breakpoints compare a thread pc against their own address register.
module hbwu_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic debugMode,
    input wire hbwu_pkg::hbwu_op_t issueOp,
    input wire hbwu_pkg::hbwu_op_t memOp,
    input wire hbwu_pkg::hbwu_op_t resOp,
    output logic debugIrq
);

    typedef struct packed {
        hbwu_pkg::hbwu_bus_state_t busState;
        logic [31:0] rdata;
        logic irq;
        logic [3:0][31:0] instructionBreakpointAddress;
        hbwu_pkg::hbwu_ctl_t [3:0] ibCtl;
        logic [3:0][31:0] dwFirst;
        logic [3:0][31:0] dwSecond;
        hbwu_pkg::hbwu_ctl_t [3:0] dwCtl;
        logic [3:0][31:0] rwMask;
        logic [3:0][31:0] rwValue;
        hbwu_pkg::hbwu_ctl_t [3:0] rwCtl;
        logic [2:0] causeCode;
        logic [7:0] causeThread;
        logic [1:0] causeNum;
        logic [31:0] causeData;
    } hbwu_state_t;

    hbwu_state_t state_r;
    hbwu_state_t state_nxt;

    // control register as software sees it; reserved bits read zero
    function automatic logic [31:0] ctlToWord(input hbwu_pkg::hbwu_ctl_t c);
        logic [31:0] w;
        w = hbwu_pkg::RST_WORD;
        w[hbwu_pkg::CTL_MASK_MSB:hbwu_pkg::CTL_MASK_LSB] = c.threadMask;
        w[hbwu_pkg::CTL_LOAD_BIT] = c.onLoads;
        w[hbwu_pkg::CTL_COND_BIT] = c.cond;
        w[hbwu_pkg::CTL_EN_BIT] = c.enable;
        return w;
    endfunction

    function automatic hbwu_pkg::hbwu_ctl_t wordToCtl(input logic [31:0] w, input logic hasLoad);
        hbwu_pkg::hbwu_ctl_t c;
        c.threadMask = w[hbwu_pkg::CTL_MASK_MSB:hbwu_pkg::CTL_MASK_LSB];
        c.onLoads = w[hbwu_pkg::CTL_LOAD_BIT] & hasLoad;
        c.cond = w[hbwu_pkg::CTL_COND_BIT];
        c.enable = w[hbwu_pkg::CTL_EN_BIT];
        return c;
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return m;
    endfunction

    // bank match on the upper index bits, four words per bank
    function automatic logic inBank(input logic [7:0] idx, input logic [7:0] base);
        return idx[7:2] == base[7:2];
    endfunction

    // register groups behind the bus decode
    typedef enum logic [3:0] {
        HBWU_G_NONE = 4'h0,
        HBWU_G_TYPE = 4'h1,
        HBWU_G_DATA = 4'h2,
        HBWU_G_IB_ADDR = 4'h3,
        HBWU_G_IB_CTL = 4'h4,
        HBWU_G_DW_FIRST = 4'h5,
        HBWU_G_DW_SECOND = 4'h6,
        HBWU_G_DW_CTL = 4'h7,
        HBWU_G_RW_MASK = 4'h8,
        HBWU_G_RW_VALUE = 4'h9,
        HBWU_G_RW_CTL = 4'hA
    } hbwu_group_t;

    // one decode for the read mux and the write path, so the two cannot drift apart
    function automatic hbwu_group_t regGroup(input logic [7:0] idx);
        hbwu_group_t g;
        g = HBWU_G_NONE;
        if (idx == hbwu_pkg::IDX_IRQ_TYPE) begin
            g = HBWU_G_TYPE;
        end else if (idx == hbwu_pkg::IDX_IRQ_DATA) begin
            g = HBWU_G_DATA;
        end else if (inBank(idx, hbwu_pkg::IDX_IB_ADDR)) begin
            g = HBWU_G_IB_ADDR;
        end else if (inBank(idx, hbwu_pkg::IDX_IB_CTL)) begin
            g = HBWU_G_IB_CTL;
        end else if (inBank(idx, hbwu_pkg::IDX_DW_FIRST)) begin
            g = HBWU_G_DW_FIRST;
        end else if (inBank(idx, hbwu_pkg::IDX_DW_SECOND)) begin
            g = HBWU_G_DW_SECOND;
        end else if (inBank(idx, hbwu_pkg::IDX_DW_CTL)) begin
            g = HBWU_G_DW_CTL;
        end else if (inBank(idx, hbwu_pkg::IDX_RW_MASK)) begin
            g = HBWU_G_RW_MASK;
        end else if (inBank(idx, hbwu_pkg::IDX_RW_VALUE)) begin
            g = HBWU_G_RW_VALUE;
        end else if (inBank(idx, hbwu_pkg::IDX_RW_CTL)) begin
            g = HBWU_G_RW_CTL;
        end
        return g;
    endfunction

    logic [7:0] regIdx;
    logic [1:0] sub;
    assign regIdx = wb_adr_i[9:2];
    assign sub = regIdx[1:0];
    hbwu_group_t regGrp;
    assign regGrp = regGroup(regIdx);

    logic [3:0] ibHit;
    logic [3:0] dwHit;
    logic [3:0] rwHit;

    // per-point comparators, all evaluated in the cycle the operation is offered
    for (genvar i = 0; i < hbwu_pkg::NUM_POINTS; i++) begin : g_cmp
        logic pcEq;
        logic condA;
        logic condB;
        logic dwKind;
        logic resEq;
        assign pcEq = issueOp.value == state_r.instructionBreakpointAddress[i];
        assign condA = memOp.value >= state_r.dwFirst[i];
        assign condB = memOp.value <= state_r.dwSecond[i];
        assign dwKind = ~memOp.isLoad | state_r.dwCtl[i].onLoads;
        assign resEq = (resOp.value & state_r.rwMask[i]) == state_r.rwValue[i];
        assign ibHit[i] = issueOp.valid & state_r.ibCtl[i].enable
                          & state_r.ibCtl[i].threadMask[issueOp.thread]
                          & (state_r.ibCtl[i].cond ? ~pcEq : pcEq);
        assign dwHit[i] = memOp.valid & state_r.dwCtl[i].enable & dwKind
                          & state_r.dwCtl[i].threadMask[memOp.thread]
                          & (state_r.dwCtl[i].cond ? (condA | condB) : (condA & condB));
        assign rwHit[i] = resOp.valid & state_r.rwCtl[i].enable
                          & state_r.rwCtl[i].threadMask[resOp.thread]
                          & (state_r.rwCtl[i].cond ? ~resEq : resEq);
    end

    // lowest set bit of a hit vector
    function automatic logic [1:0] lowestHit(input logic [3:0] h);
        logic [1:0] n;
        n = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (h[k]) begin
                n = 2'(k);
            end
        end
        return n;
    endfunction

    // next state: bus slave, register writes, trigger capture
    always_comb begin
        logic take;
        logic wr;
        logic [31:0] rd;
        logic [31:0] mw; // merged write word
        take = 1'b0;
        mw = hbwu_pkg::RST_WORD;
        wr = 1'b0;
        rd = hbwu_pkg::RST_WORD;
        state_nxt = state_r;
        state_nxt.irq = 1'b0;

        // read mux; unmapped indices read zero
        if (regGrp == HBWU_G_TYPE) begin
            rd[hbwu_pkg::TYPE_CAUSE_MSB:hbwu_pkg::TYPE_CAUSE_LSB] = state_r.causeCode;
            rd[hbwu_pkg::TYPE_THREAD_MSB:hbwu_pkg::TYPE_THREAD_LSB] = state_r.causeThread;
            rd[hbwu_pkg::TYPE_NUM_MSB:hbwu_pkg::TYPE_NUM_LSB] = state_r.causeNum;
        end else if (regGrp == HBWU_G_DATA) begin
            rd = state_r.causeData;
        end else if (regGrp == HBWU_G_IB_ADDR) begin
            rd = state_r.instructionBreakpointAddress[sub];
        end else if (regGrp == HBWU_G_IB_CTL) begin
            rd = ctlToWord(state_r.ibCtl[sub]);
        end else if (regGrp == HBWU_G_DW_FIRST) begin
            rd = state_r.dwFirst[sub];
        end else if (regGrp == HBWU_G_DW_SECOND) begin
            rd = state_r.dwSecond[sub];
        end else if (regGrp == HBWU_G_DW_CTL) begin
            rd = ctlToWord(state_r.dwCtl[sub]);
        end else if (regGrp == HBWU_G_RW_MASK) begin
            rd = state_r.rwMask[sub];
        end else if (regGrp == HBWU_G_RW_VALUE) begin
            rd = state_r.rwValue[sub];
        end else if (regGrp == HBWU_G_RW_CTL) begin
            rd = ctlToWord(state_r.rwCtl[sub]);
        end

        // single-cycle answer, ack dropped the cycle after it was given
        case (state_r.busState)
            hbwu_pkg::HBWU_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    take = 1'b1;
                    state_nxt.busState = hbwu_pkg::HBWU_ACK;
                    state_nxt.rdata = wb_we_i ? hbwu_pkg::RST_WORD : rd;
                end
            end
            hbwu_pkg::HBWU_ACK: begin
                state_nxt.busState = hbwu_pkg::HBWU_IDLE;
            end
            default: begin
                state_nxt.busState = hbwu_pkg::HBWU_IDLE;
            end
        endcase

        // writes land only in debug mode; outside it they are acked and dropped
        wr = take & wb_we_i & debugMode;
        mw = laneMerge(rd, wb_dat_i, wb_sel_i);
        if (wr) begin
            if (regGrp == HBWU_G_TYPE) begin
                state_nxt.causeCode = mw[hbwu_pkg::TYPE_CAUSE_MSB:hbwu_pkg::TYPE_CAUSE_LSB];
                state_nxt.causeThread = mw[hbwu_pkg::TYPE_THREAD_MSB:hbwu_pkg::TYPE_THREAD_LSB];
                state_nxt.causeNum = mw[hbwu_pkg::TYPE_NUM_MSB:hbwu_pkg::TYPE_NUM_LSB];
            end else if (regGrp == HBWU_G_DATA) begin
                state_nxt.causeData = mw;
            end else if (regGrp == HBWU_G_IB_ADDR) begin
                state_nxt.instructionBreakpointAddress[sub] = mw;
            end else if (regGrp == HBWU_G_IB_CTL) begin
                state_nxt.ibCtl[sub] = wordToCtl(mw, 1'b0);
            end else if (regGrp == HBWU_G_DW_FIRST) begin
                state_nxt.dwFirst[sub] = mw;
            end else if (regGrp == HBWU_G_DW_SECOND) begin
                state_nxt.dwSecond[sub] = mw;
            end else if (regGrp == HBWU_G_DW_CTL) begin
                state_nxt.dwCtl[sub] = wordToCtl(mw, 1'b1);
            end else if (regGrp == HBWU_G_RW_MASK) begin
                state_nxt.rwMask[sub] = mw;
            end else if (regGrp == HBWU_G_RW_VALUE) begin
                state_nxt.rwValue[sub] = mw;
            end else if (regGrp == HBWU_G_RW_CTL) begin
                state_nxt.rwCtl[sub] = wordToCtl(mw, 1'b0);
            end
        end

        // capture after the bus write so a hit wins over a same-cycle write;
        // no triggers while the debugger already holds the tile
        if (!debugMode) begin
            if (|ibHit) begin
                state_nxt.irq = 1'b1;
                state_nxt.causeCode = hbwu_pkg::CAUSE_INSTR;
                state_nxt.causeThread = {5'h00, issueOp.thread};
                state_nxt.causeNum = lowestHit(ibHit);
            end else if (|dwHit) begin
                state_nxt.irq = 1'b1;
                state_nxt.causeCode = hbwu_pkg::CAUSE_DATA;
                state_nxt.causeThread = {5'h00, memOp.thread};
                state_nxt.causeNum = lowestHit(dwHit);
                state_nxt.causeData = memOp.value;
            end else if (|rwHit) begin
                state_nxt.irq = 1'b1;
                state_nxt.causeCode = hbwu_pkg::CAUSE_RES;
                state_nxt.causeThread = {5'h00, resOp.thread};
                state_nxt.causeNum = lowestHit(rwHit);
                state_nxt.causeData = resOp.value;
            end
        end
    end

    // whole state in one register; every field has a defined reset value
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= '0;
            state_r.busState <= hbwu_pkg::HBWU_IDLE;
            state_r.causeCode <= hbwu_pkg::RST_CAUSE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state register
    assign wb_ack_o = state_r.busState == hbwu_pkg::HBWU_ACK;
    assign wb_dat_o = state_r.rdata;
    assign debugIrq = state_r.irq;

endmodule

// >>> hbwu_pkg.sv
package hbwu_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_IRQ_TYPE = 8'h15;
    localparam logic [7:0] IDX_IRQ_DATA = 8'h16;
    localparam logic [7:0] IDX_IB_ADDR = 8'h30;
    localparam logic [7:0] IDX_IB_CTL = 8'h40;
    localparam logic [7:0] IDX_DW_FIRST = 8'h50;
    localparam logic [7:0] IDX_DW_SECOND = 8'h60;
    localparam logic [7:0] IDX_DW_CTL = 8'h70;
    localparam logic [7:0] IDX_RW_MASK = 8'h80;
    localparam logic [7:0] IDX_RW_VALUE = 8'h90;
    localparam logic [7:0] IDX_RW_CTL = 8'h9C;

    // control register field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_COND_BIT = 1;
    localparam int CTL_LOAD_BIT = 2;
    localparam int CTL_MASK_LSB = 16;
    localparam int CTL_MASK_MSB = 23;

    // cause record field positions
    localparam int TYPE_CAUSE_LSB = 0;
    localparam int TYPE_CAUSE_MSB = 2;
    localparam int TYPE_THREAD_LSB = 8;
    localparam int TYPE_THREAD_MSB = 15;
    localparam int TYPE_NUM_LSB = 16;
    localparam int TYPE_NUM_MSB = 17;

    // cause codes
    localparam logic [2:0] CAUSE_INSTR = 3'h3;
    localparam logic [2:0] CAUSE_DATA = 3'h4;
    localparam logic [2:0] CAUSE_RES = 3'h5;

    // values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [2:0] RST_CAUSE = 3'h0;

    localparam int NUM_POINTS = 4;
    localparam int NUM_THREADS = 8;

    typedef enum logic [0:0] {
        HBWU_IDLE = 1'b0,
        HBWU_ACK = 1'b1
    } hbwu_bus_state_t;

    // stored part of a control register
    typedef struct packed {
        logic [7:0] threadMask;
        logic onLoads;
        logic cond;
        logic enable;
    } hbwu_ctl_t;

    // one instruction issue, memory access or resource operation
    typedef struct packed {
        logic valid;
        logic [2:0] thread;
        logic isLoad;
        logic [31:0] value;
    } hbwu_op_t;

endpackage

// >>> hbwu_top_assertions.sv
module hbwu_top_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic debugMode,
    input wire hbwu_pkg::hbwu_op_t issueOp,
    input wire hbwu_pkg::hbwu_op_t memOp,
    input wire hbwu_pkg::hbwu_op_t resOp,
    input wire logic debugIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic armed_r;
    logic armed_nxt;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // controls reset to zero, so nothing fires before a debug-mode write
    always_comb begin
        armed_nxt = armed_r | (wb_cyc_i & wb_stb_i & wb_we_i & debugMode);
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
        end
    end
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_write_data_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("read data not zero on write");
    a_irq_needs_op: assert property (debugIrq |-> $past(issueOp.valid || memOp.valid || resOp.valid))
        else $error("interrupt without an operation");
    a_irq_not_debug: assert property (debugIrq |-> !$past(debugMode))
        else $error("interrupt from an op in debug mode");
    a_irq_needs_arm: assert property (debugIrq |-> $past(armed_r))
        else $error("interrupt from a point never enabled");
    a_debug_quiet: assert property (debugMode [*2] |-> !debugIrq)
        else $error("interrupt while in debug mode");
    c_read: cover property (wb_ack_o && !$past(wb_we_i));
    c_irq: cover property (debugIrq);
    c_all_ops: cover property (issueOp.valid && memOp.valid && resOp.valid);
endmodule
bind hbwu_top hbwu_top_assertions hbwu_top_assertions_i (.ref_clk, .rst, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .debugMode, .issueOp,
    .memOp, .resOp, .debugIrq);

// >>> hbwu_pipe_model.sv
module hbwu_pipe_model (
    input wire logic ref_clk,
    output hbwu_pkg::hbwu_op_t issueOp,
    output hbwu_pkg::hbwu_op_t memOp,
    output hbwu_pkg::hbwu_op_t resOp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        issueOp = '0;
        memOp = '0;
        resOp = '0;
    end
    // one cycle per op; stale fields flip so nothing reads old values
    task automatic send(input hbwu_pkg::hbwu_op_t i, m, r);
        issueOp <= i;
        memOp <= m;
        resOp <= r;
        @(posedge ref_clk);
        issueOp <= {1'b0, ~i[35:0]};
        memOp <= {1'b0, ~m[35:0]};
        resOp <= {1'b0, ~r[35:0]};
    endtask
endmodule

// >>> hbwu_top_tb.sv
module hbwu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error %0t: value mismatch", $time); end end
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] wbAdr = '0, wbDat = '0, wbDatO, q, w, expData = '0;
    logic wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, debugMode = 1'b0, wbAck, debugIrq, dm;
    logic [3:0] wbSel = 4'hF;
    hbwu_pkg::hbwu_op_t iOp, mOp, rOp, op[3];
    int bad_count = 0, checks = 0, p, e, ek, h;
    integer seed = 32'h5A96;
    logic [31:0] ra[3][4], rb[3][4], rc[3][4];
    // per class: first bank, second bank, control bank, stored control bits
    localparam logic [7:0] BA[3] = '{8'h30, 8'h50, 8'h80};
    localparam logic [7:0] BB[3] = '{8'h30, 8'h60, 8'h90};
    localparam logic [7:0] CI[3] = '{8'h40, 8'h70, 8'h9C};
    localparam logic [31:0] CM[3] = '{32'h00FF0003, 32'h00FF0007, 32'h00FF0003};
    always #2.5 ref_clk = ~ref_clk;
    hbwu_top hbwu_top_i (.ref_clk, .rst, .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel),
        .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .debugMode, .issueOp(iOp), .memOp(mOp), .resOp(rOp), .debugIrq);
    hbwu_pipe_model hbwu_pipe_model_i (.ref_clk, .issueOp(iOp), .memOp(mOp), .resOp(rOp));
    function automatic logic [31:0] rnd();
        return $random(seed);
    endfunction
    // lowest point of a class that should fire on this op, or -1
    function automatic int hit(int k, hbwu_pkg::hbwu_op_t o);
        logic a, b, f;
        logic [31:0] c;
        for (int i = 0; i < 4; i++) begin
            c = rc[k][i];
            a = o.value >= ra[1][i];
            b = o.value <= rb[1][i];
            case (k)
                0: f = (o.value == ra[0][i]) ^ c[1];
                1: f = (c[1] ? (a | b) : (a & b)) & (!o.isLoad | c[2]);
                default: f = ((o.value & ra[2][i]) == rb[2][i]) ^ c[1];
            endcase
            if (f && c[0] && c[16 + o.thread] && o.valid) return i;
        end
        return -1;
    endfunction
    // classic single cycle; waits on ack, never a fixed count
    task automatic wb(input logic we, input logic [7:0] ix, input logic [31:0] d,
            output logic [31:0] r);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {22'h0, ix, 2'h0};
        wbDat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
            report_and_stop();
        end
        r = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // controls read zero after reset, unmapped index reads zero
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 4; i++) begin
                wb(1'b0, CI[k] + 8'(i), 32'h0, q);
                `CHK(q, 32'h0)
            end
        end
        wb(1'b0, 8'hFF, 32'h0, q);
        `CHK(q, 32'h0)
        // writes outside debug mode are dropped
        wb(1'b1, 8'h40, 32'hFFFFFFFF, q);
        wb(1'b0, 8'h40, 32'h0, q);
        `CHK(q, 32'h0)
        // byte lanes merge into the stored word; only lanes 0 and 2 change
        debugMode <= 1'b1;
        wb(1'b1, 8'h30, 32'h11223344, q);
        wbSel <= 4'h5;
        wb(1'b1, 8'h30, 32'hAABBCCDD, q);
        wbSel <= 4'hF;
        wb(1'b0, 8'h30, 32'h0, q);
        `CHK(q, 32'h11BB33DD)
        for (int it = 0; it < 150; it++) begin
            p = int'(rnd() % 4);
            debugMode <= 1'b1;
            // reprogram one point of each class, reserved bits written with random values
            for (int k = 0; k < 3; k++) begin
                ra[k][p] = (k == 1) ? (rnd() & 32'hFF) : rnd();
                rb[k][p] = (k == 1) ? ra[k][p] + (rnd() & 32'h7F) : (rnd() & ra[k][p]);
                w = rnd() | {31'h0, it % 4 != 0};
                rc[k][p] = w & CM[k];
                wb(1'b1, BA[k] + 8'(p), ra[k][p], q);
                if (k > 0) wb(1'b1, BB[k] + 8'(p), rb[k][p], q);
                wb(1'b1, CI[k] + 8'(p), w, q);
                wb(1'b0, CI[k] + 8'(p), 32'h0, q);
                `CHK(q, rc[k][p])
                wb(1'b0, BB[k] + 8'(p), 32'h0, q);
                `CHK(q, (k == 0) ? ra[0][p] : rb[k][p])
                wb(1'b0, BA[k] + 8'(p), 32'h0, q);
                `CHK(q, ra[k][p])
            end
            // random ops on all three classes in one cycle, boundary values likely
            dm = (it % 8 == 7);
            e = -1;
            for (int k = 2; k >= 0; k--) begin
                w = rnd();
                op[k] = {w[0], w[3:1], w[4], 32'h0};
                op[k].value = w[6:5] == 0 ? ra[k][p] : w[6:5] == 1 ? rb[k][p] :
                    (rnd() & (k == 1 ? 32'h1FF : 32'hFFFFFFFF));
                h = hit(k, op[k]);
                if (h >= 0 && !dm) begin
                    e = h;
                    ek = k;
                end
            end
            debugMode <= dm;
            hbwu_pipe_model_i.send(op[0], op[1], op[2]);
            @(posedge ref_clk);
            `CHK(debugIrq, e >= 0)
            if (e >= 0) begin
                if (ek > 0) expData = op[ek].value;
                wb(1'b0, 8'h15, 32'h0, q);
                `CHK(q, {14'h0, 2'(e), 5'h0, op[ek].thread, 5'h0, 3'(ek + 3)})
                wb(1'b0, 8'h16, 32'h0, q);
                `CHK(q, expData)
            end
        end
        report_and_stop();
    end
endmodule
